// ### pkg/port_reset_pkg.sv
// constants and types for the port reset and link event handler
package port_reset_pkg;
	// clock rate and silence interval
	localparam int unsigned clock_hz = 40_000_000;
	localparam int unsigned silence_us = 1000;
	localparam int unsigned silence_cycles = clock_hz / 1_000_000 * silence_us;
	// phys in the port and identifier range
	localparam int unsigned phy_count = 4;
	localparam logic [7:0] phy_id_base = 8'h00;
	localparam logic [7:0] phy_id_limit = 8'h40;
	// nexus loss limit: 16-bit count of microseconds
	localparam int unsigned nexus_w = 16;
	localparam int unsigned cycles_per_us = clock_hz / 1_000_000;
	// sense data for the unit attention
	localparam logic [3:0] sense_unit_attention = 4'h6;
	localparam logic [7:0] asc_hard_reset = 8'h29;
	localparam logic [7:0] ascq_hard_reset = 8'h02;
	// device kind
	localparam logic kind_sas = 1'b0;
	localparam logic kind_ata = 1'b1;
	// reset sequencer states
	typedef enum logic [4:0] {
		st_idle = 5'b0_0001,
		st_silent = 5'b0_0010,
		st_link_reset = 5'b0_0100,
		st_wait_link = 5'b0_1000,
		st_attention = 5'b1_0000
	} seq_e;
	// retry states
	typedef enum logic [2:0] {
		rt_idle = 3'b001,
		rt_retry = 3'b010,
		rt_lost = 3'b100
	} retry_e;
endpackage

// ### src/port_reset_event_handler.sv
// per-port hard reset, loss of signal silence and nexus loss retry logic
module port_reset_event_handler
	import port_reset_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// configuration, held static by the device
	input wire logic device_kind,
	input wire logic is_target,
	input wire logic [63:0] device_name,
	input wire logic [nexus_w-1:0] nexus_limit_us,
	// per-phy link events, from the phy pins
	input wire logic [phy_count-1:0] hard_reset_seen,
	input wire logic [phy_count-1:0] link_reset_done,
	input wire logic [phy_count-1:0] identify_seen,
	input wire logic [phy_count-1:0] signal_lost,
	// connection request results, same clock
	input wire logic open_request,
	input wire logic reject_no_dest,
	input wire logic open_accept,
	input wire logic unit_attention_clear,
	// phy controls
	output logic [phy_count-1:0] tx_disable,
	output logic [phy_count-1:0] link_reset_start,
	output logic [phy_count*8-1:0] phy_ids,
	output logic [63:0] port_id,
	// reset actions
	output logic scsi_hard_reset,
	output logic ata_hw_reset,
	// unit attention
	output logic unit_attention,
	output logic [3:0] sense_key,
	output logic [7:0] sense_asc,
	output logic [7:0] sense_ascq,
	// connection retry
	output logic open_retry,
	output logic nexus_loss
);
	localparam int unsigned sw = $clog2(silence_cycles + 1);
	localparam int unsigned uw = $clog2(cycles_per_us + 1);

	typedef struct packed {
		// pin synchronisers and edge history
		logic [phy_count-1:0] hr_s1;
		logic [phy_count-1:0] hr_s2;
		logic [phy_count-1:0] lr_s1;
		logic [phy_count-1:0] lr_s2;
		logic [phy_count-1:0] lr_d;
		logic [phy_count-1:0] id_s1;
		logic [phy_count-1:0] id_s2;
		logic [phy_count-1:0] ls_s1;
		logic [phy_count-1:0] ls_s2;
		logic [phy_count-1:0] ls_d;
		logic [phy_count-1:0] id_window;
		// silence timers, one per phy and one for the port
		logic [phy_count-1:0][sw-1:0] phy_cnt;
		logic [sw-1:0] port_cnt;
		// reset sequencer
		seq_e seq;
		logic [phy_count-1:0] lr_pending;
		// retry timer
		retry_e rt;
		logic [uw-1:0] us_cnt;
		logic [nexus_w-1:0] nexus_cnt;
		// registered outputs
		logic [phy_count-1:0] tx_disable;
		logic [phy_count-1:0] link_reset_start;
		logic scsi_hard_reset;
		logic ata_hw_reset;
		logic unit_attention;
		logic [3:0] sense_key;
		logic [7:0] sense_asc;
		logic [7:0] sense_ascq;
		logic open_retry;
		logic nexus_loss;
		logic [63:0] port_id;
		logic [phy_count*8-1:0] phy_ids;
	} state_s;

	state_s r, next_r;

	// fixed identifier for each phy, unique and below the limit
	function automatic logic [7:0] phy_id_of(input int unsigned i);
		phy_id_of = phy_id_base + i[7:0];
	endfunction

	// whole identifier table, also the reset value of the output
	function automatic logic [phy_count*8-1:0] phy_id_table();
		logic [phy_count*8-1:0] t;
		t = '0;
		for (int i = 0; i < phy_count; i++) begin
			t[i*8 +: 8] = (phy_id_of(i) < phy_id_limit) ?
				phy_id_of(i) : phy_id_base;
		end
		return t;
	endfunction

	// constant table, so the reset branch loads only a constant
	localparam logic [phy_count*8-1:0] phy_id_init = phy_id_table();

	// next state
	always_comb begin
		logic hard_evt;
		logic [phy_count-1:0] lr_rise, ls_rise;
		hard_evt = 1'b0;
		lr_rise = '0;
		ls_rise = '0;
		next_r = r;
		// pins pass two flip-flops before use
		next_r.hr_s1 = hard_reset_seen;
		next_r.hr_s2 = r.hr_s1;
		next_r.lr_s1 = link_reset_done;
		next_r.lr_s2 = r.lr_s1;
		next_r.lr_d = r.lr_s2;
		next_r.id_s1 = identify_seen;
		next_r.id_s2 = r.id_s1;
		next_r.ls_s1 = signal_lost;
		next_r.ls_s2 = r.ls_s1;
		next_r.ls_d = r.ls_s2;
		lr_rise = r.lr_s2 & ~r.lr_d;
		ls_rise = r.ls_s2 & ~r.ls_d;
		next_r.link_reset_start = '0;
		next_r.scsi_hard_reset = 1'b0;
		next_r.ata_hw_reset = 1'b0;
		next_r.open_retry = 1'b0;
		next_r.port_id = device_name;
		// window opens at link reset end, closes on identify frame
		for (int i = 0; i < phy_count; i++) begin
			if (lr_rise[i])
				next_r.id_window[i] = 1'b1;
			else if (r.id_s2[i])
				next_r.id_window[i] = 1'b0;
		end
		if (|(r.hr_s2 & r.id_window))
			hard_evt = 1'b1;
		// sata target takes link reset as hard reset
		// sas link reset is minor
		// link resets are taken only in the idle and attention states, so silent-state ones are excluded too
		if (device_kind == kind_ata && is_target && |lr_rise &&
				(r.seq == st_idle || r.seq == st_attention))
			hard_evt = 1'b1;
		// per-phy loss of signal silence
		for (int i = 0; i < phy_count; i++) begin
			if (ls_rise[i])
				next_r.phy_cnt[i] = sw'(silence_cycles);
			else if (r.phy_cnt[i] != '0)
				next_r.phy_cnt[i] = r.phy_cnt[i] - 1'b1;
		end
		// loss of signal never touches the sequencer
		// port reset sequencer
		case (r.seq)
			st_idle, st_attention: begin
				if (hard_evt) begin
					next_r.seq = st_silent;
					next_r.port_cnt = sw'(silence_cycles);
					next_r.scsi_hard_reset = (device_kind == kind_sas);
					next_r.ata_hw_reset = (device_kind == kind_ata);
					next_r.unit_attention = 1'b0;
				end else if (r.seq == st_attention && unit_attention_clear)
					next_r.seq = st_idle;
			end
			st_silent: begin
				// all phys silent for 1 ms
				// restart on a fresh hard reset
				if (|(r.hr_s2 & r.id_window))
					next_r.port_cnt = sw'(silence_cycles);
				else if (r.port_cnt > sw'(1))
					next_r.port_cnt = r.port_cnt - 1'b1;
				else begin
					next_r.port_cnt = '0;
					next_r.seq = st_link_reset;
				end
			end
			st_link_reset: begin
				next_r.link_reset_start = '1;
				next_r.lr_pending = '1;
				next_r.seq = st_wait_link;
			end
			st_wait_link: begin
				next_r.lr_pending = r.lr_pending & ~lr_rise;
				if ((r.lr_pending & ~lr_rise) == '0) begin
					next_r.unit_attention = is_target;
					next_r.seq = is_target ? st_attention : st_idle;
				end
			end
			default: next_r.seq = st_idle;
		endcase
		// attention cleared by software path unless set again
		if (r.seq == st_attention && unit_attention_clear && !hard_evt)
			next_r.unit_attention = 1'b0;
		// sense data registered together with the attention flag
		if (next_r.unit_attention) begin
			next_r.sense_key = sense_unit_attention;
			next_r.sense_asc = asc_hard_reset;
			next_r.sense_ascq = ascq_hard_reset;
		end else begin
			next_r.sense_key = '0;
			next_r.sense_asc = '0;
			next_r.sense_ascq = '0;
		end
		// identifiers are fixed, kept in a register for a clean output
		next_r.phy_ids = phy_id_init;
		// transmit disable from port and phy silence
		for (int i = 0; i < phy_count; i++)
			next_r.tx_disable[i] = (next_r.seq == st_silent) ||
				(next_r.phy_cnt[i] != '0);
		// nexus loss retry timer
		case (r.rt)
			rt_idle: begin
				if (reject_no_dest) begin
					next_r.rt = rt_retry;
					next_r.us_cnt = uw'(cycles_per_us);
					next_r.nexus_cnt = nexus_limit_us;
					next_r.open_retry = 1'b1;
				end
			end
			rt_retry: begin
				if (open_accept)
					next_r.rt = rt_idle;
				else begin
					if (reject_no_dest)
						next_r.open_retry = 1'b1;
					if (r.us_cnt > uw'(1))
						next_r.us_cnt = r.us_cnt - 1'b1;
					else begin
						next_r.us_cnt = uw'(cycles_per_us);
						if (r.nexus_cnt != '0)
							next_r.nexus_cnt = r.nexus_cnt - 1'b1;
					end
					// rejections at expiry declare nexus loss
					if (r.nexus_cnt == '0 && reject_no_dest) begin
						next_r.rt = rt_lost;
						next_r.nexus_loss = 1'b1;
						next_r.open_retry = 1'b0;
					end
				end
			end
			rt_lost: begin
				// loss stays until the next new request
				if (open_request) begin
					next_r.rt = rt_idle;
					next_r.nexus_loss = 1'b0;
				end
			end
			default: next_r.rt = rt_idle;
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.seq <= st_idle;
			r.rt <= rt_idle;
			r.phy_ids <= phy_id_init;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flip-flops
	assign tx_disable = r.tx_disable;
	assign link_reset_start = r.link_reset_start;
	assign port_id = r.port_id;
	assign scsi_hard_reset = r.scsi_hard_reset;
	assign ata_hw_reset = r.ata_hw_reset;
	assign unit_attention = r.unit_attention;
	// sense data for hard reset occurred
	assign sense_key = r.sense_key;
	assign sense_asc = r.sense_asc;
	assign sense_ascq = r.sense_ascq;
	assign phy_ids = r.phy_ids;
	assign open_retry = r.open_retry;
	assign nexus_loss = r.nexus_loss;
endmodule

// ### verif/port_reset_properties.sv
// assertions on the port reset event handler ports
module port_reset_checker
	import port_reset_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// watched ports
	input wire logic device_kind,
	input wire logic [3:0] signal_lost,
	input wire logic reject_no_dest,
	input wire logic [3:0] tx_disable,
	input wire logic [3:0] link_reset_start,
	input wire logic [31:0] phy_ids,
	input wire logic scsi_hard_reset,
	input wire logic ata_hw_reset,
	input wire logic unit_attention,
	input wire logic [3:0] sense_key,
	input wire logic [7:0] sense_asc,
	input wire logic [7:0] sense_ascq,
	input wire logic open_retry,
	input wire logic nexus_loss
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// sense data, fixed identifiers, reset silence and kind, link reset, loss of signal and retry
	property p_sense;
		unit_attention |->
			{sense_key, sense_asc, sense_ascq} == 20'h6_2902;
	endproperty
	a_sense: assert property (p_sense) else $error("bad sense");
	property p_ids;
		phy_ids == 32'h0302_0100;
	endproperty
	a_ids: assert property (p_ids) else $error("bad phy ids");
	property p_silent;
		scsi_hard_reset || ata_hw_reset |-> tx_disable == 4'hf;
	endproperty
	a_silent: assert property (p_silent) else $error("not silent");
	property p_kind;
		scsi_hard_reset || ata_hw_reset |->
			ata_hw_reset == (device_kind == kind_ata);
	endproperty
	a_kind: assert property (p_kind) else $error("wrong reset kind");
	property p_link;
		$rose(|link_reset_start) |->
			link_reset_start == 4'hf ##1 link_reset_start == 4'h0;
	endproperty
	a_link: assert property (p_link) else $error("bad link reset");
	property p_los;
		$rose(signal_lost[0]) |-> ##[2:4] tx_disable[0];
	endproperty
	a_los: assert property (p_los) else $error("loss not silent");
	property p_retry;
		open_retry |-> $past(reject_no_dest) && !nexus_loss;
	endproperty
	a_retry: assert property (p_retry) else $error("stray retry");
	property p_loss;
		$rose(nexus_loss) |-> !open_retry && $past(reject_no_dest);
	endproperty
	a_loss: assert property (p_loss) else $error("bad loss");
	// main scenarios reached
	c_scsi: cover property (scsi_hard_reset);
	c_ata: cover property (ata_hw_reset);
	c_loss: cover property ($rose(nexus_loss));
endmodule
bind port_reset_event_handler port_reset_checker port_reset_checker_i (
	.clock, .rst_n, .device_kind, .signal_lost, .reject_no_dest, .tx_disable,
	.link_reset_start, .phy_ids, .scsi_hard_reset, .ata_hw_reset,
	.unit_attention, .sense_key, .sense_asc, .sense_ascq, .open_retry,
	.nexus_loss
);

// ### verif/far_phy_model.sv
// attached phy model answering link reset requests
module far_phy_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// link reset requests in, completion levels out
	input wire logic [3:0] lr_req,
	output logic [3:0] link_reset_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt;
	// never sends hard reset itself
	// done drops during the sequence so the port sees a fresh rise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			link_reset_done <= 4'h0;
		end else if (|lr_req) begin
			cnt <= 4'h8;
			link_reset_done <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			link_reset_done <= {4{cnt == 4'h1}};
		end
	end
endmodule

// ### verif/tb.sv
// self-checking bench for the port reset event handler
module tb
	import port_reset_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0, rst_n = 1'b0, device_kind = kind_sas;
	logic is_target = 1'b1, open_request = 1'b0, reject_no_dest = 1'b0;
	logic open_accept = 1'b0, unit_attention_clear = 1'b0;
	logic [63:0] device_name = 64'h0123_4567_89ab_cdef, port_id;
	logic [15:0] nexus_limit_us = 16'h0002;
	logic [3:0] hard_reset_seen = 4'h0, identify_seen = 4'h0;
	logic [3:0] signal_lost = 4'h0, tb_lr = 4'h0, link_reset_done;
	logic [3:0] tx_disable, link_reset_start, sense_key;
	logic [7:0] sense_asc, sense_ascq;
	logic [31:0] phy_ids;
	logic scsi_hard_reset, ata_hw_reset, unit_attention, open_retry, nexus_loss;
	int err_count = 0, checks = 0, n_hr = 0, n_rt = 0, i;
	port_reset_event_handler port_reset_event_handler_i (
		.clock, .rst_n, .device_kind, .is_target, .device_name,
		.nexus_limit_us, .hard_reset_seen, .link_reset_done, .identify_seen,
		.signal_lost, .open_request, .reject_no_dest, .open_accept,
		.unit_attention_clear, .tx_disable, .link_reset_start, .phy_ids,
		.port_id, .scsi_hard_reset, .ata_hw_reset, .unit_attention, .sense_key,
		.sense_asc, .sense_ascq, .open_retry, .nexus_loss
	);
	far_phy_model far_phy_model_i (.clock, .rst_n,
		.lr_req(link_reset_start | tb_lr), .link_reset_done);
	always #12.5 clock = ~clock;
	// event counts, so one-cycle pulses are never missed
	always @(posedge clock) begin
		n_hr <= n_hr + int'(scsi_hard_reset | ata_hw_reset);
		n_rt <= n_rt + int'(open_retry);
	end
	task chk(input logic [63:0] seen, input logic [63:0] want);
		checks++;
		if (seen !== want) begin
			err_count++;
			$display("[FAIL] %0t %h %h", $time, seen, want);
		end
	endtask
	task end_sim;
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task rej;
		reject_no_dest = 1'b1;
		@(negedge clock);
		reject_no_dest = 1'b0;
		repeat (3) @(negedge clock);
	endtask
	// retrigger early so the first interval alone would have ended
	task t_los;
		signal_lost = 4'h1;
		repeat (100) @(negedge clock);
		signal_lost = 4'h0;
		repeat (5) @(negedge clock);
		signal_lost = 4'h1;
		repeat (silence_cycles - 50) @(negedge clock);
		chk(tx_disable, 4'h1); // restarted
		chk(n_hr, 0); // no port reset
		chk(port_id, device_name); // device name as identifier
		chk(phy_ids, 32'h0302_0100); // fixed identifiers
		repeat (100) @(negedge clock);
		chk(tx_disable, 4'h0); // silence over
	endtask
	task t_nexus;
		rej();
		chk(n_rt, 1); // first retry
		rej();
		chk(n_rt, 2); // still retrying
		repeat (cycles_per_us * 3) @(negedge clock);
		rej();
		chk({nexus_loss, n_rt[3:0]}, 5'h12); // loss, no retry
		open_request = 1'b1;
		@(negedge clock);
		open_request = 1'b0;
		@(negedge clock);
		chk(nexus_loss, 1'b0); // cleared
		// an accepted connection ends the retry, a late reject starts afresh
		rej();
		open_accept = 1'b1;
		@(negedge clock);
		open_accept = 1'b0;
		repeat (cycles_per_us * 3) @(negedge clock);
		rej();
		chk({nexus_loss, n_rt[3:0]}, 5'h04); // fresh retry after accept
	endtask
	task t_hard;
		// open the window, then let the identify frame close it
		tb_lr = 4'hf;
		@(negedge clock);
		tb_lr = 4'h0;
		repeat (16) @(negedge clock);
		identify_seen = 4'hf;
		repeat (4) @(negedge clock);
		hard_reset_seen = 4'hf;
		repeat (8) @(negedge clock);
		chk(n_hr, 0); // ignored
		hard_reset_seen = 4'h0;
		identify_seen = 4'h0;
		tb_lr = 4'hf;
		@(negedge clock);
		tb_lr = 4'h0;
		repeat (16) @(negedge clock);
		hard_reset_seen = 4'hf;
		for (i = 0; i < 8 && scsi_hard_reset !== 1'b1; i++) @(negedge clock);
		chk({scsi_hard_reset, tx_disable}, 5'h1f); // reset
		hard_reset_seen = 4'h0;
		for (i = 0; i < silence_cycles + 9 && link_reset_start !== 4'hf; i++)
			@(negedge clock);
		chk({i > silence_cycles - 9, link_reset_start}, 5'h1f);
		for (i = 0; i < 30 && unit_attention !== 1'b1; i++) @(negedge clock);
		chk({sense_key, sense_asc, sense_ascq}, 20'h6_2902);
		unit_attention_clear = 1'b1;
		@(negedge clock);
		unit_attention_clear = 1'b0;
		chk({unit_attention, sense_key}, 5'h00); // attention cleared
	endtask
	task t_ata;
		rst_n = 1'b0;
		device_kind = kind_ata;
		@(negedge clock);
		rst_n = 1'b1;
		tb_lr = 4'hf;
		@(negedge clock);
		tb_lr = 4'h0;
		for (i = 0; i < 20 && ata_hw_reset !== 1'b1; i++) @(negedge clock);
		chk({ata_hw_reset, scsi_hard_reset}, 2'h2); // ata reset
	endtask
	initial begin
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		t_los();
		t_nexus();
		t_hard();
		t_ata();
		end_sim();
	end
	// two silence intervals plus margin
	initial begin
		#2_300_000;
		err_count++;
		end_sim();
	end
endmodule
